/* core/cot_pkg.sv */
// package for the charger option and throttle configuration block
// assumes a 25 MHz device clock and registers written through a simple word port
package cot_pkg;
    // register offsets and reset values
    localparam logic [7:0]  OFS_CHARGE_OPTION_THREE   = 8'h32;
    localparam logic [7:0]  OFS_THROTTLE_OPTION_ZERO  = 8'h33;
    localparam logic [15:0] RST_CHARGE_OPTION_THREE   = 16'h0000;
    localparam logic [15:0] RST_THROTTLE_OPTION_ZERO  = 16'h4a54;

    // first option register fields
    localparam int BIT_STANDBY_HIGHZ_ENABLE      = 15;
    localparam int BIT_REGISTER_RESET            = 14;
    localparam int BIT_FLOOR_REMEASURE           = 13;
    localparam int BIT_OPTIMIZER_ENABLE          = 11;
    localparam int BIT_SWITCH_OFF_IN_STANDBY     = 1;

    // throttle register fields
    localparam int POS_SECOND_LIMIT_LSB          = 11;
    localparam int POS_CRIT_DEGLITCH_LSB         = 9;
    localparam int POS_SYS_THRESHOLD_LSB         = 6;
    localparam int BIT_PULSE_EXTEND_ENABLE       = 5;
    localparam int POS_PULSE_WIDTH_LSB           = 3;
    localparam int BIT_PULSE_CLEAR               = 2;

    // second input limit code map, in percent of the input current limit
    localparam logic [4:0]  LIMIT_CODE_LAST_FINE  = 5'h19;
    localparam logic [4:0]  LIMIT_CODE_IGNORED    = 5'h1f;
    localparam logic [8:0]  LIMIT_FINE_BASE_PCT   = 9'd105;
    localparam logic [8:0]  LIMIT_FINE_STEP_PCT   = 9'd5;
    localparam logic [8:0]  LIMIT_COARSE_BASE_PCT = 9'd250;
    localparam logic [8:0]  LIMIT_COARSE_STEP_PCT = 9'd50;
    localparam logic [4:0]  LIMIT_COARSE_FIRST    = 5'h1a;
    // critical level is 110 percent of the second limit
    localparam logic [13:0] CRIT_NUM              = 14'd11;
    localparam logic [13:0] CRIT_DEN              = 14'd10;

    // system rail thresholds in millivolts
    localparam logic [12:0] SYS_MULTI_BASE_MV     = 13'd5750;
    localparam logic [12:0] SYS_SINGLE_BASE_MV    = 13'd2850;
    localparam logic [12:0] SYS_STEP_MV           = 13'd250;

    // timing, in nanoseconds, and derived cycle counts
    localparam int unsigned CLK_PERIOD_NS     = 40;
    localparam int unsigned T_CRIT_15US_NS    = 15000;
    localparam int unsigned T_CRIT_100US_NS   = 100000;
    localparam int unsigned T_CRIT_400US_NS   = 400000;
    localparam int unsigned T_CRIT_800US_NS   = 800000;
    localparam int unsigned T_SYS_DEG_NS      = 20000;
    localparam int unsigned T_WIDTH_100US_NS  = 100000;
    localparam int unsigned T_WIDTH_1MS_NS    = 1000000;
    localparam int unsigned T_WIDTH_5MS_NS    = 5000000;
    localparam int unsigned T_WIDTH_10MS_NS   = 10000000;
    localparam int unsigned CYC_CRIT_15US   = (T_CRIT_15US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_CRIT_100US  = (T_CRIT_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_CRIT_400US  = (T_CRIT_400US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_CRIT_800US  = (T_CRIT_800US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_SYS_DEG     = (T_SYS_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_WIDTH_100US = (T_WIDTH_100US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_WIDTH_1MS   = (T_WIDTH_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_WIDTH_5MS   = (T_WIDTH_5MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_WIDTH_10MS  = (T_WIDTH_10MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // throttle pulse states
    typedef enum logic [2:0] {
        COT_IDLE     = 3'b001,
        COT_HOLD_MIN = 3'b010,
        COT_HOLD_EXT = 3'b100
    } cot_pulse_e;
endpackage

/* core/cot_option_throttle.sv */
// charger option and throttle configuration registers with the throttle pulse logic
// assumes a word-wide register write/read port behind the host serial engine,
// current and rail readings from the converter on the same clock
//
// Notes on behaviour
// - Bit 15 of the first option register puts the device in standby, regulator kept on above undervoltage, system fed from battery.
// - Writing 1 to bit 14 restores all registers but the input voltage floor to defaults and reads back 0.
// - Writing 1 to bit 13 stops the converter while the input voltage floor is measured, then the bit clears and the converter restarts.
// - Bit 11 enables the input current optimizer, off after reset.
// - Bit 1 turns the battery switch off during standby when 1, on when 0.
// - The 5-bit second limit code maps 1..25 to 110..230 percent in 5 steps, 26..30 to 250..450 in 50 steps, 31 ignored.
// - A throttle trigger occurs when input current exceeds the second limit, default code 01001 for 150 percent.
// - The critical current level is 110 percent of the second limit.
// - Bits 10-9 pick the critical deglitch: 15 us, 100 us, 400 us or 800 us.
// - A system rail below its threshold for a fixed 20 us triggers throttling.
// - Bits 7-6 pick the rail threshold from 5.75 V or 2.85 V in 0.25 V steps, default 01.
// - With extension bit 5 set the throttle output stays low after a trigger until the host writes 0 to bit 2.
// - Without extension bits 4-3 set the least pulse width: 100 us, 1 ms, 10 ms or 5 ms.
// - Writing 0 to the pulse clear bit ends an extended pulse and drives the output high if no trigger is present; 1 is idle.
module cot_option_throttle
    import cot_pkg::*;
#(
    parameter int unsigned CRIT_400US_CYC = cot_pkg::CYC_CRIT_400US,
    parameter int unsigned CRIT_800US_CYC = cot_pkg::CYC_CRIT_800US,
    parameter int unsigned WIDTH_1MS_CYC  = cot_pkg::CYC_WIDTH_1MS,
    parameter int unsigned WIDTH_5MS_CYC  = cot_pkg::CYC_WIDTH_5MS,
    parameter int unsigned WIDTH_10MS_CYC = cot_pkg::CYC_WIDTH_10MS
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             defaults_restore,
    input  wire logic        input_above_uvlo,
    input  wire logic        floor_measure_done,
    output logic             converter_disable,
    output logic             standby_highz_enable,
    output logic             internal_regulator_on,
    output logic             system_from_battery,
    output logic             battery_switch_on,
    output logic             input_current_optimizer_enable,
    input  wire logic [9:0]  input_current_pct,
    input  wire logic [12:0] system_voltage_mv,
    input  wire logic        single_cell,
    output logic             processor_throttle_output_n
);
    import cot_pkg::*;

    // second limit code to percent of the input current limit
    function automatic logic [8:0] limit_pct(input logic [4:0] code);
        logic [8:0] c;
        c = {4'h0, code};
        if (code <= LIMIT_CODE_LAST_FINE) begin
            limit_pct = 9'(LIMIT_FINE_BASE_PCT + c * LIMIT_FINE_STEP_PCT);
        end else begin
            limit_pct = 9'(LIMIT_COARSE_BASE_PCT + (c - {4'h0, LIMIT_COARSE_FIRST}) * LIMIT_COARSE_STEP_PCT);
        end
    endfunction

    logic [15:0] charge_option_three;
    logic [15:0] throttle_option_zero;
    logic        remeasure_pending;
    logic [1:0]  uvlo_sync;
    logic [1:0]  done_sync;
    logic [14:0] crit_cnt;
    logic [8:0]  sys_cnt;
    logic [17:0] width_cnt;
    cot_pulse_e  state;
    cot_pulse_e  next_state;

    // write decode
    wire         wr_opt3        = reg_write && (reg_addr == OFS_CHARGE_OPTION_THREE);
    wire         wr_thr0        = reg_write && (reg_addr == OFS_THROTTLE_OPTION_ZERO);
    wire         reg_reset_req  = wr_opt3 && reg_wdata[BIT_REGISTER_RESET];
    wire         clear_write    = wr_thr0 && !reg_reset_req && !reg_wdata[BIT_PULSE_CLEAR];
    wire         done_seen      = done_sync[1];

    // field views
    wire [4:0]   limit_code     = throttle_option_zero[POS_SECOND_LIMIT_LSB +: 5];
    wire [1:0]   crit_sel       = throttle_option_zero[POS_CRIT_DEGLITCH_LSB +: 2];
    wire [1:0]   sys_sel        = throttle_option_zero[POS_SYS_THRESHOLD_LSB +: 2];
    wire         extend_en      = throttle_option_zero[BIT_PULSE_EXTEND_ENABLE];
    wire [1:0]   width_sel      = throttle_option_zero[POS_PULSE_WIDTH_LSB +: 2];

    // current comparisons, critical at 110 percent of the second limit
    wire         limit_valid    = (limit_code != LIMIT_CODE_IGNORED) && (limit_code != 5'h00);
    wire [13:0]  limit_pct_w    = {5'h00, limit_pct(limit_code)};
    wire         ilim2_over     = limit_valid && ({4'h0, input_current_pct} > limit_pct_w);
    wire         crit_over      = limit_valid
                                  && (14'({4'h0, input_current_pct} * CRIT_DEN) > 14'(limit_pct_w * CRIT_NUM));
    wire [14:0]  crit_limit     = (crit_sel == 2'b00) ? 15'(CYC_CRIT_15US)
                                : (crit_sel == 2'b01) ? 15'(CYC_CRIT_100US)
                                : (crit_sel == 2'b10) ? 15'(CRIT_400US_CYC)
                                :                       15'(CRIT_800US_CYC);
    wire         crit_trip      = crit_over && (crit_cnt >= crit_limit);

    // rail threshold and fixed deglitch
    wire [12:0]  sys_base       = single_cell ? SYS_SINGLE_BASE_MV : SYS_MULTI_BASE_MV;
    wire [12:0]  sys_thresh     = 13'(sys_base + {11'h000, sys_sel} * SYS_STEP_MV);
    wire         sys_below      = system_voltage_mv < sys_thresh;
    wire         sys_trip       = sys_below && (sys_cnt >= 9'(CYC_SYS_DEG));
    wire         trigger        = ilim2_over || crit_trip || sys_trip;

    // least pulse width for the chosen code
    wire [17:0]  width_load     = (width_sel == 2'b00) ? 18'(CYC_WIDTH_100US)
                                : (width_sel == 2'b01) ? 18'(WIDTH_1MS_CYC)
                                : (width_sel == 2'b10) ? 18'(WIDTH_10MS_CYC)
                                :                        18'(WIDTH_5MS_CYC);

    // register file; reset request restores defaults and is never stored
    always_ff @(posedge ref_clk) begin
        if (reset || reg_reset_req) begin
            charge_option_three  <= RST_CHARGE_OPTION_THREE;
            throttle_option_zero <= RST_THROTTLE_OPTION_ZERO;
        end else if (wr_opt3) begin
            charge_option_three  <= reg_wdata & ~(16'h1 << BIT_FLOOR_REMEASURE);
        end else if (wr_thr0) begin
            throttle_option_zero <= reg_wdata | (16'h1 << BIT_PULSE_CLEAR);
        end
    end

    // floor re-measure request; a new request wins over completion
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            remeasure_pending <= 1'b0;
        end else if (wr_opt3 && !reg_reset_req && reg_wdata[BIT_FLOOR_REMEASURE]) begin
            remeasure_pending <= 1'b1;
        end else if (done_seen) begin
            remeasure_pending <= 1'b0;
        end
    end

    // synchronisers for analog-side levels
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            uvlo_sync <= 2'b00;
            done_sync <= 2'b00;
        end else begin
            uvlo_sync <= {uvlo_sync[0], input_above_uvlo};
            done_sync <= {done_sync[0], floor_measure_done};
        end
    end

    // deglitch counters count consecutive cycles over the critical level or below the rail threshold
    always_ff @(posedge ref_clk) begin
        if (reset || !crit_over) begin
            crit_cnt <= 15'h0000;
        end else if (crit_cnt != 15'h7fff) begin
            crit_cnt <= crit_cnt + 15'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || !sys_below) begin
            sys_cnt <= 9'h000;
        end else if (!sys_trip) begin
            sys_cnt <= sys_cnt + 9'h001;
        end
    end

    // throttle pulse sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            COT_IDLE: begin
                if (trigger) begin
                    next_state = extend_en ? COT_HOLD_EXT : COT_HOLD_MIN;
                end
            end
            COT_HOLD_MIN: begin
                if (width_cnt == 18'h00000 && !trigger) begin
                    next_state = COT_IDLE;
                end
            end
            COT_HOLD_EXT: begin
                if (clear_write && !trigger) begin
                    next_state = COT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= COT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            width_cnt <= 18'h00000;
        end else if (state == COT_IDLE) begin
            width_cnt <= width_load - 18'h00001;
        end else if (width_cnt != 18'h00000) begin
            width_cnt <= width_cnt - 18'h00001;
        end
    end

    // registered outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata                   <= 16'h0000;
            defaults_restore            <= 1'b0;
            processor_throttle_output_n <= 1'b1;
        end else begin
            reg_rdata <= (reg_addr == OFS_CHARGE_OPTION_THREE)
                             ? (charge_option_three | ({15'h0000, remeasure_pending} << BIT_FLOOR_REMEASURE))
                       : (reg_addr == OFS_THROTTLE_OPTION_ZERO) ? throttle_option_zero
                       : 16'h0000;
            defaults_restore            <= reg_reset_req;
            processor_throttle_output_n <= (next_state == COT_IDLE);
        end
    end

    // configuration levels toward the power stage
    assign converter_disable              = remeasure_pending;
    assign standby_highz_enable           = charge_option_three[BIT_STANDBY_HIGHZ_ENABLE];
    assign internal_regulator_on          = !standby_highz_enable || uvlo_sync[1];
    assign system_from_battery            = standby_highz_enable;
    assign battery_switch_on              = !(standby_highz_enable
                                              && charge_option_three[BIT_SWITCH_OFF_IN_STANDBY]);
    assign input_current_optimizer_enable = charge_option_three[BIT_OPTIMIZER_ENABLE];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    reset_request_a: assert property (reg_reset_req |=> charge_option_three == RST_CHARGE_OPTION_THREE
        && throttle_option_zero == RST_THROTTLE_OPTION_ZERO && defaults_restore)
        else $error("register reset did not restore defaults");
    remeasure_stop_a: assert property (wr_opt3 && !reg_reset_req && reg_wdata[BIT_FLOOR_REMEASURE]
        |=> converter_disable)
        else $error("converter ran during floor measurement");
    remeasure_hold_a: assert property (converter_disable && !done_seen |=> converter_disable)
        else $error("converter restarted before measurement done");
    remeasure_end_a: assert property (remeasure_pending && done_seen && !wr_opt3 |=> !converter_disable)
        else $error("remeasure bit did not clear on completion");
    standby_feed_a: assert property (standby_highz_enable |-> system_from_battery
        && (internal_regulator_on == uvlo_sync[1]))
        else $error("standby feed or regulator wrong");
    switch_standby_a: assert property (!standby_highz_enable |-> battery_switch_on)
        else $error("battery switch off outside standby");
    optimizer_follow_a: assert property (wr_opt3 && !reg_reset_req
        |=> input_current_optimizer_enable == $past(reg_wdata[BIT_OPTIMIZER_ENABLE]))
        else $error("optimizer enable not following write");
    code_ignored_a: assert property (limit_code == LIMIT_CODE_IGNORED |-> !ilim2_over && !crit_over)
        else $error("ignored limit code compared");
    limit_trigger_a: assert property (state == COT_IDLE && ilim2_over |=> !processor_throttle_output_n)
        else $error("limit crossing did not throttle");
    crit_filter_a: assert property (crit_trip |-> $past(crit_over) && crit_cnt >= 15'(CYC_CRIT_15US))
        else $error("critical trip without deglitch");
    rail_filter_a: assert property (!sys_below ##1 sys_below [*8] |-> !sys_trip)
        else $error("rail trip before deglitch");
    extend_hold_a: assert property (state == COT_HOLD_EXT && !clear_write |=> !processor_throttle_output_n)
        else $error("extended pulse ended without clear");
    clear_release_a: assert property (state == COT_HOLD_EXT && clear_write && !trigger
        |=> processor_throttle_output_n)
        else $error("clear write did not release throttle");
    least_width_a: assert property ($rose(state == COT_HOLD_MIN) |-> !processor_throttle_output_n [*8])
        else $error("throttle pulse shorter than minimum");
endmodule

/* test/cot_converter_model.sv */
// converter side model: answers a floor remeasure request with a done level
// assumes the same device clock as the block and a synchronous active-high reset
module cot_converter_model #(
    parameter int unsigned MEASURE_CYC = 10
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic converter_disable,
    output logic      floor_measure_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned count;

    // done rises a fixed time after the converter stops, drops once it restarts
    always_ff @(posedge ref_clk) begin
        if (reset || !converter_disable) begin
            count <= 0;
            floor_measure_done <= 1'b0;
        end else if (count == MEASURE_CYC) begin
            floor_measure_done <= 1'b1;
        end else begin
            count <= count + 1;
        end
    end
endmodule

/* test/charger_option_throttle_config_tb_top.sv */
// testbench for the option and throttle registers, driven on the falling edge
// assumes the converter model beside the block and shortened pulse counts
module charger_option_throttle_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cot_pkg::*;
    localparam int W1 = 20;
    localparam int W5 = 30;
    localparam int W10 = 40;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        reg_write = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        input_above_uvlo = 1'b1;
    logic [9:0]  input_current_pct = 10'h000;
    logic [12:0] system_voltage_mv = 13'd8000;
    logic        single_cell = 1'b0;
    logic [15:0] reg_rdata;
    logic        defaults_restore, floor_measure_done, converter_disable, standby_highz_enable;
    logic        internal_regulator_on, system_from_battery, battery_switch_on;
    logic        input_current_optimizer_enable, processor_throttle_output_n;
    int          mismatches = 0, check_count = 0, cycles = 0, n, thr;
    int          wid[4] = '{CYC_WIDTH_100US, W1, W10, W5};
    int          codes[6] = '{1, 25, 26, 30, 0, 31};

    cot_option_throttle #(.CRIT_400US_CYC(40), .CRIT_800US_CYC(80), .WIDTH_1MS_CYC(W1),
        .WIDTH_5MS_CYC(W5), .WIDTH_10MS_CYC(W10)) dut (
        .ref_clk(ref_clk), .reset(reset), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .defaults_restore(defaults_restore),
        .input_above_uvlo(input_above_uvlo), .floor_measure_done(floor_measure_done),
        .converter_disable(converter_disable), .standby_highz_enable(standby_highz_enable),
        .internal_regulator_on(internal_regulator_on), .system_from_battery(system_from_battery),
        .battery_switch_on(battery_switch_on),
        .input_current_optimizer_enable(input_current_optimizer_enable),
        .input_current_pct(input_current_pct), .system_voltage_mv(system_voltage_mv),
        .single_cell(single_cell), .processor_throttle_output_n(processor_throttle_output_n));

    cot_converter_model #(.MEASURE_CYC(10)) conv (.ref_clk(ref_clk), .reset(reset),
        .converter_disable(converter_disable), .floor_measure_done(floor_measure_done));

    // clock and cycle ceiling
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_n(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    // one write strobe, entered and left at a falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        wait_n(1);
        reg_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        wait_n(1);
        check(reg_rdata, exp);
    endtask

    // over-limit current for exactly one sampled edge
    task automatic fire(input logic [9:0] p);
        input_current_pct = p;
        wait_n(1);
        input_current_pct = 10'd0;
    endtask

    function automatic logic [15:0] opt0(input logic [4:0] lim, input logic [1:0] vth,
                                         input logic ext, input logic [1:0] w);
        return {lim, 2'b01, 1'b0, vth, ext, w, 3'b100};
    endfunction

    initial begin
        wait_n(12);
        reset = 1'b0;
        wait_n(1);
        rd(OFS_CHARGE_OPTION_THREE, RST_CHARGE_OPTION_THREE);
        rd(OFS_THROTTLE_OPTION_ZERO, RST_THROTTLE_OPTION_ZERO);
        wr(8'h40, 16'hffff);
        rd(8'h40, 16'h0000);
        check(input_current_optimizer_enable, 1'b0);
        input_current_pct = 10'd150;
        wait_n(4);
        check(processor_throttle_output_n, 1'b1);
        fire(10'd151);
        wait_n(1);
        check(processor_throttle_output_n, 1'b0);
        wait_n(60);
        $display("test defaults done");
        wr(OFS_CHARGE_OPTION_THREE, 16'h8802);
        rd(OFS_CHARGE_OPTION_THREE, 16'h8802);
        check({standby_highz_enable, system_from_battery}, 2'b11);
        check(battery_switch_on, 1'b0);
        check(input_current_optimizer_enable, 1'b1);
        input_above_uvlo = 1'b0;
        wait_n(4);
        check(internal_regulator_on, 1'b0);
        input_above_uvlo = 1'b1;
        wait_n(4);
        check(internal_regulator_on, 1'b1);
        wr(OFS_CHARGE_OPTION_THREE, 16'h8000);
        check(battery_switch_on, 1'b1);
        wait_n(1);
        wr(OFS_CHARGE_OPTION_THREE, 16'h17fd);
        rd(OFS_CHARGE_OPTION_THREE, 16'h17fd);
        check({standby_highz_enable, input_current_optimizer_enable, converter_disable}, 3'b000);
        $display("test standby done");
        wr(OFS_THROTTLE_OPTION_ZERO, 16'h1231);
        rd(OFS_THROTTLE_OPTION_ZERO, 16'h1235);
        wr(OFS_CHARGE_OPTION_THREE, 16'h4800);
        check(defaults_restore, 1'b1);
        wait_n(1);
        check(defaults_restore, 1'b0);
        rd(OFS_THROTTLE_OPTION_ZERO, RST_THROTTLE_OPTION_ZERO);
        rd(OFS_CHARGE_OPTION_THREE, 16'h0000);
        $display("test register reset done");
        wr(OFS_CHARGE_OPTION_THREE, 16'h2000);
        check(converter_disable, 1'b1);
        rd(OFS_CHARGE_OPTION_THREE, 16'h2000);
        n = 0;
        while (converter_disable === 1'b1 && n < 40) begin
            wait_n(1);
            n++;
        end
        check(n >= 10 && n <= 18, 1'b1);
        rd(OFS_CHARGE_OPTION_THREE, 16'h0000);
        $display("test remeasure done");
        // minimum width for every width code
        for (int w = 0; w < 4; w++) begin
            wr(OFS_THROTTLE_OPTION_ZERO, opt0(5'd9, 2'b01, 1'b0, w[1:0]));
            fire(10'd151);
            n = 0;
            while (processor_throttle_output_n !== 1'b1 && n < 3000) begin
                wait_n(1);
                n++;
            end
            check(n >= wid[w] - 1 && n <= wid[w] + 2, 1'b1);
            wait_n(2);
        end
        $display("test width done");
        // limit code map edges and the ignored codes
        for (int i = 0; i < 6; i++) begin
            wr(OFS_THROTTLE_OPTION_ZERO, opt0(codes[i][4:0], 2'b01, 1'b0, 2'b01));
            thr = (codes[i] == 0 || codes[i] == 31) ? 1022 : (codes[i] <= 25) ? 105 + 5 * codes[i]
                : 250 + 50 * (codes[i] - 26);
            input_current_pct = thr[9:0];
            wait_n(20);
            check(processor_throttle_output_n, 1'b1);
            input_current_pct = thr[9:0] + 10'd1;
            wait_n(2);
            check(processor_throttle_output_n, thr == 1022);
            input_current_pct = 10'd0;
            wait_n(30);
        end
        $display("test limit codes done");
        // rail thresholds for both cell counts
        for (int c = 0; c < 8; c++) begin
            single_cell = c[2];
            wr(OFS_THROTTLE_OPTION_ZERO, opt0(5'd9, c[1:0], 1'b0, 2'b01));
            thr = (c[2] ? 2850 : 5750) + 250 * c[1:0];
            system_voltage_mv = thr[12:0];
            wait_n(520);
            check(processor_throttle_output_n, 1'b1);
            system_voltage_mv = thr[12:0] - 13'd1;
            wait_n(490);
            check(processor_throttle_output_n, 1'b1);
            wait_n(15);
            check(processor_throttle_output_n, 1'b0);
            system_voltage_mv = 13'd8000;
            wait_n(40);
        end
        single_cell = 1'b0;
        $display("test rail done");
        wr(OFS_THROTTLE_OPTION_ZERO, opt0(5'd9, 2'b01, 1'b1, 2'b01));
        fire(10'd200);
        wait_n(100);
        check(processor_throttle_output_n, 1'b0);
        input_current_pct = 10'd200;
        wait_n(2510); // long over-current lets the critical deglitch run out
        wr(OFS_THROTTLE_OPTION_ZERO, opt0(5'd9, 2'b01, 1'b1, 2'b01) ^ 16'h0004);
        wait_n(2);
        check(processor_throttle_output_n, 1'b0);
        input_current_pct = 10'd0;
        wait_n(2);
        check(processor_throttle_output_n, 1'b0);
        wr(OFS_THROTTLE_OPTION_ZERO, opt0(5'd9, 2'b01, 1'b1, 2'b01) ^ 16'h0004);
        wait_n(1);
        check(processor_throttle_output_n, 1'b1);
        $display("test extension done");
        close_out();
    end
endmodule
